//--- core/sram_port.sv
// Synchronous control port of an 18-bit pipelined burst SRAM, with its scan port.
// Assumes a two-port cell array outside: asynchronous read, write committed on the clock.
//
// Overview of operation
// - Clock gate high at an edge: the edge is ignored; pipeline and burst state hold, while write strobe, standby and output enables still update.
// - Read/write sampled at load fixes the direction for the whole burst.
// - Data moves exactly two cycles after its address and control were sampled.
// - Everything acts on the rising edge, output enable, snooze and burst order included; output enable and snooze also act on gated edges.
// - Any chip select false with load sampled starts a deselect cycle.
// - Two cycles after a deselect the data pins float; pending transfers finish.
// - Active-high select behaves like the active-low ones; all three must be true.
// - Output enable high keeps the data pins floating.
// - Load with the chip selected captures address and control, starting an access.
// - Advance steps the burst counter of the burst in progress.
// - On advance the address pins and read/write are ignored.
// - Burst order high selects interleaved order, low selects linear order.
// - Snooze high puts the device in standby.
// - Write data in and read data out are registered; bus is two byte lanes.
// - A boundary-scan test port with mode, data in, clock and data out.
// - Low two address bits at load seed the burst counter.
// - Per-lane active-low byte writes, valid each write cycle, used two cycles later.
// - After the fourth address the counter wraps and keeps counting.
`timescale 1ns/1ps
module sram_port (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_gate_b_i,
    input wire logic [sram_port_pkg::ADDR_W-1:0] addr_i,
    input wire logic read_not_write_i,
    input wire logic advance_or_load_i,
    input wire logic chip_sel_b_i,
    input wire logic chip_sel_low_b_i,
    input wire logic chip_sel_high_i,
    input wire logic [sram_port_pkg::LANES-1:0] byte_write_low_i,
    input wire logic out_en_b_i,
    input wire logic snooze_request_i,
    input wire logic burst_order_i,
    input wire logic [sram_port_pkg::DATA_W-1:0] data_pin_i,
    output logic [sram_port_pkg::DATA_W-1:0] data_pin_o,
    output logic [sram_port_pkg::LANES-1:0] data_pin_oe_o,
    output logic [sram_port_pkg::ADDR_W-1:0] core_rd_addr_o,
    output logic core_rd_o,
    input wire logic [sram_port_pkg::DATA_W-1:0] core_rd_data_i,
    output logic [sram_port_pkg::ADDR_W-1:0] core_wr_addr_o,
    output logic core_wr_o,
    output logic [sram_port_pkg::LANES-1:0] core_wr_lane_o,
    output logic [sram_port_pkg::DATA_W-1:0] core_wr_data_o,
    output logic standby_o,
    input wire logic test_clk_i,
    input wire logic test_mode_i,
    input wire logic test_data_i,
    output logic test_data_o,
    output logic test_data_oe_o
);

    typedef struct packed {
        // Burst tracker
        logic burst_live;
        sram_port_pkg::op_type burst_op;
        logic [sram_port_pkg::ADDR_W-1:0] burst_base;
        logic [sram_port_pkg::BURST_W-1:0] burst_start;
        logic [sram_port_pkg::BURST_W-1:0] burst_step;
        // Two-stage command pipeline
        sram_port_pkg::cmd_type stage1;
        sram_port_pkg::cmd_type stage2;
        // Array side
        logic [sram_port_pkg::ADDR_W-1:0] rd_addr;
        logic rd;
        logic [sram_port_pkg::ADDR_W-1:0] wr_addr;
        logic wr;
        logic [sram_port_pkg::LANES-1:0] wr_lane;
        logic [sram_port_pkg::DATA_W-1:0] wr_data;
        // Pin side
        logic [sram_port_pkg::DATA_W-1:0] dout;
        logic drive;
        logic [sram_port_pkg::LANES-1:0] dout_oe;
        logic standby;
    } port_type;

    port_type cur;
    port_type next_cur;

    logic selected;
    logic edge_live;
    logic [sram_port_pkg::BURST_W-1:0] next_step;
    logic [sram_port_pkg::BURST_W-1:0] burst_off;
    sram_port_pkg::cmd_type issue;
    logic [sram_port_pkg::DATA_W-1:0] fwd_data;

    // Last-written data bypasses the array when a read lands on it one edge early
    genvar lane;
    generate
        for (lane = 0; lane < sram_port_pkg::LANES; lane++)
        begin : g_fwd
            localparam int LO = lane * sram_port_pkg::LANE_W;
            logic hit;
            assign hit = cur.wr && cur.wr_lane[lane] && (cur.wr_addr == cur.rd_addr);
            assign fwd_data[LO +: sram_port_pkg::LANE_W] = hit ?
                cur.wr_data[LO +: sram_port_pkg::LANE_W] :
                core_rd_data_i[LO +: sram_port_pkg::LANE_W];
        end
    endgenerate

    always_comb
    begin
        next_cur = cur;
        // All three selects must be true at once
        selected = ~chip_sel_b_i & ~chip_sel_low_b_i & chip_sel_high_i;
        // Snooze freezes the pipeline as a held clock would
        edge_live = ~clk_gate_b_i & ~snooze_request_i;
        next_step = cur.burst_step + sram_port_pkg::BURST_STEP_ONE;
        if (burst_order_i)
            burst_off = cur.burst_start ^ next_step;
        else
            burst_off = cur.burst_start + next_step;
        issue = '0;

        // Array write strobe is a single pulse even if the next edge is gated
        next_cur.wr = 1'b0;
        next_cur.standby = snooze_request_i;

        if (edge_live)
        begin
            if (!advance_or_load_i)
            begin
                if (selected)
                begin
                    // New access: address, direction and burst seed captured
                    next_cur.burst_live = 1'b1;
                    next_cur.burst_op = read_not_write_i ? sram_port_pkg::op_read : sram_port_pkg::op_write;
                    next_cur.burst_base = addr_i;
                    next_cur.burst_start = addr_i[sram_port_pkg::BURST_W-1:0];
                    next_cur.burst_step = sram_port_pkg::BURST_STEP_FIRST;
                    issue.op = next_cur.burst_op;
                    issue.addr = addr_i;
                end
                else
                begin
                    // Deselect ends any burst; older transfers still drain
                    next_cur.burst_live = 1'b0;
                    issue.op = sram_port_pkg::op_none;
                end
            end
            else if (cur.burst_live)
            begin
                // Pins for address and direction are not looked at here
                next_cur.burst_step = next_step;
                issue.op = cur.burst_op;
                issue.addr = {cur.burst_base[sram_port_pkg::ADDR_W-1:sram_port_pkg::BURST_W], burst_off};
            end
            // Byte enables count only on write cycles
            if (issue.op == sram_port_pkg::op_write)
                issue.lane_wr = ~byte_write_low_i;

            next_cur.stage1 = issue;
            next_cur.stage2 = cur.stage1;

            // Second edge: present the read address to the array
            next_cur.rd = (cur.stage1.op == sram_port_pkg::op_read);
            if (cur.stage1.op == sram_port_pkg::op_read)
                next_cur.rd_addr = cur.stage1.addr;

            // Third edge: the transfer of the command sampled two edges back
            if (cur.stage2.op == sram_port_pkg::op_write)
            begin
                next_cur.wr = |cur.stage2.lane_wr;
                next_cur.wr_addr = cur.stage2.addr;
                next_cur.wr_lane = cur.stage2.lane_wr;
                next_cur.wr_data = data_pin_i;
            end
            next_cur.drive = (cur.stage2.op == sram_port_pkg::op_read);
            if (cur.stage2.op == sram_port_pkg::op_read)
                next_cur.dout = fwd_data;
        end

        // Output enable gates the drivers each cycle even while the clock is held
        next_cur.dout_oe = {sram_port_pkg::LANES{next_cur.drive & ~out_en_b_i & ~snooze_request_i}};
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign data_pin_o = cur.dout;
    assign data_pin_oe_o = cur.dout_oe;
    assign core_rd_addr_o = cur.rd_addr;
    assign core_rd_o = cur.rd;
    assign core_wr_addr_o = cur.wr_addr;
    assign core_wr_o = cur.wr;
    assign core_wr_lane_o = cur.wr_lane;
    assign core_wr_data_o = cur.wr_data;
    assign standby_o = cur.standby;

    sram_scan_tap u_tap (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .test_clk_i(test_clk_i),
        .test_mode_i(test_mode_i),
        .test_data_i(test_data_i),
        .test_data_o(test_data_o),
        .test_data_oe_o(test_data_oe_o)
    );

endmodule

//--- core/sram_port_pkg.sv
// Shared widths, encodings and state enumerations for the pipelined SRAM port.
// Assumes one 20 MHz system clock; all pins are sampled on its rising edge.
package sram_port_pkg;

    localparam int ADDR_W = 19;
    localparam int LANES = 2;
    localparam int LANE_W = 9;
    localparam int DATA_W = 18;
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_STEP_FIRST = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP_ONE = 2'h1;

    localparam real CLK_PERIOD_NS = 50.0;

    typedef enum logic [1:0] {op_none, op_read, op_write} op_type;

    typedef struct packed {
        op_type op;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_wr;
    } cmd_type;

    localparam int IR_W = 2;
    localparam int ID_W = 32;
    localparam logic [IR_W-1:0] IR_IDCODE = 2'h1;
    localparam logic [IR_W-1:0] IR_BYPASS = 2'h3;
    localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;
    localparam logic [ID_W-1:0] DR_CLEAR = 32'h0000_0000;

    typedef enum logic [3:0] {
        tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_shift_dr, tap_exit1_dr,
        tap_pause_dr, tap_exit2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_shift_ir,
        tap_exit1_ir, tap_pause_ir, tap_exit2_ir, tap_upd_ir
    } tap_state_type;

endpackage

//--- core/sram_scan_tap.sv
// Boundary-scan test access port: state machine, instruction register, bypass and identity.
// Assumes the test clock is an ordinary input sampled on clk_sys_i, well below its rate.
`timescale 1ns/1ps
module sram_scan_tap #(
    parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary identity value
)(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic test_clk_i,
    input wire logic test_mode_i,
    input wire logic test_data_i,
    output logic test_data_o,
    output logic test_data_oe_o
);
    typedef struct packed {
        logic tck_prev;
        sram_port_pkg::tap_state_type st;
        logic [sram_port_pkg::IR_W-1:0] ir;
        logic [sram_port_pkg::IR_W-1:0] ir_sh;
        logic [sram_port_pkg::ID_W-1:0] dr;
        logic tdo;
        logic tdo_oe;
    } tap_type;

    tap_type cur;
    tap_type next_cur;
    sram_port_pkg::tap_state_type nst;
    logic rise;
    logic fall;
    logic is_id;

    always_comb
    begin
        next_cur = cur;
        next_cur.tck_prev = test_clk_i;
        rise = test_clk_i & ~cur.tck_prev;
        fall = ~test_clk_i & cur.tck_prev;
        is_id = (cur.ir == sram_port_pkg::IR_IDCODE);
        nst = cur.st;
        unique case (cur.st)
            sram_port_pkg::tap_reset: nst = test_mode_i ? sram_port_pkg::tap_reset : sram_port_pkg::tap_idle;
            sram_port_pkg::tap_idle: nst = test_mode_i ? sram_port_pkg::tap_sel_dr : sram_port_pkg::tap_idle;
            sram_port_pkg::tap_sel_dr: nst = test_mode_i ? sram_port_pkg::tap_sel_ir : sram_port_pkg::tap_cap_dr;
            sram_port_pkg::tap_cap_dr: nst = test_mode_i ? sram_port_pkg::tap_exit1_dr : sram_port_pkg::tap_shift_dr;
            sram_port_pkg::tap_shift_dr: nst = test_mode_i ? sram_port_pkg::tap_exit1_dr : sram_port_pkg::tap_shift_dr;
            sram_port_pkg::tap_exit1_dr: nst = test_mode_i ? sram_port_pkg::tap_upd_dr : sram_port_pkg::tap_pause_dr;
            sram_port_pkg::tap_pause_dr: nst = test_mode_i ? sram_port_pkg::tap_exit2_dr : sram_port_pkg::tap_pause_dr;
            sram_port_pkg::tap_exit2_dr: nst = test_mode_i ? sram_port_pkg::tap_upd_dr : sram_port_pkg::tap_shift_dr;
            sram_port_pkg::tap_upd_dr: nst = test_mode_i ? sram_port_pkg::tap_sel_dr : sram_port_pkg::tap_idle;
            sram_port_pkg::tap_sel_ir: nst = test_mode_i ? sram_port_pkg::tap_reset : sram_port_pkg::tap_cap_ir;
            sram_port_pkg::tap_cap_ir: nst = test_mode_i ? sram_port_pkg::tap_exit1_ir : sram_port_pkg::tap_shift_ir;
            sram_port_pkg::tap_shift_ir: nst = test_mode_i ? sram_port_pkg::tap_exit1_ir : sram_port_pkg::tap_shift_ir;
            sram_port_pkg::tap_exit1_ir: nst = test_mode_i ? sram_port_pkg::tap_upd_ir : sram_port_pkg::tap_pause_ir;
            sram_port_pkg::tap_pause_ir: nst = test_mode_i ? sram_port_pkg::tap_exit2_ir : sram_port_pkg::tap_pause_ir;
            sram_port_pkg::tap_exit2_ir: nst = test_mode_i ? sram_port_pkg::tap_upd_ir : sram_port_pkg::tap_shift_ir;
            sram_port_pkg::tap_upd_ir: nst = test_mode_i ? sram_port_pkg::tap_sel_dr : sram_port_pkg::tap_idle;
        endcase
        if (rise)
        begin
            next_cur.st = nst;
            unique case (cur.st)
                sram_port_pkg::tap_reset: next_cur.ir = sram_port_pkg::IR_IDCODE;
                sram_port_pkg::tap_cap_dr: next_cur.dr = is_id ? ID_VALUE : sram_port_pkg::DR_CLEAR;
                sram_port_pkg::tap_shift_dr:
                begin
                    // Bypass is a one-bit path, identity a full-width shift
                    if (is_id)
                        next_cur.dr = {test_data_i, cur.dr[sram_port_pkg::ID_W-1:1]};
                    else
                        next_cur.dr = {cur.dr[sram_port_pkg::ID_W-1:1], test_data_i};
                end
                sram_port_pkg::tap_cap_ir: next_cur.ir_sh = sram_port_pkg::IR_CAPTURE;
                sram_port_pkg::tap_shift_ir: next_cur.ir_sh = {test_data_i, cur.ir_sh[sram_port_pkg::IR_W-1]};
                sram_port_pkg::tap_upd_ir: next_cur.ir = cur.ir_sh;
                default: next_cur.ir = cur.ir;
            endcase
        end
        // Output changes on the falling test clock so the far end samples it on the rise
        if (fall)
        begin
            next_cur.tdo_oe = (cur.st == sram_port_pkg::tap_shift_dr) || (cur.st == sram_port_pkg::tap_shift_ir);
            next_cur.tdo = (cur.st == sram_port_pkg::tap_shift_ir) ? cur.ir_sh[0] : cur.dr[0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign test_data_o = cur.tdo;
    assign test_data_oe_o = cur.tdo_oe;

endmodule

//--- tb/sram_cell_array.sv
// Behavioural two-port cell array behind the port's core interface.
// Keys on the low six address bits; a write pulse commits at the next edge.
`timescale 1ns/1ps
module sram_cell_array (
    input wire logic clk_sys_i,
    input wire logic [sram_port_pkg::ADDR_W-1:0] rd_addr_i,
    input wire logic rd_i,
    output logic [sram_port_pkg::DATA_W-1:0] rd_data_o,
    input wire logic [sram_port_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic wr_i,
    input wire logic [sram_port_pkg::LANES-1:0] wr_lane_i,
    input wire logic [sram_port_pkg::DATA_W-1:0] wr_data_i
);
    logic [17:0] mem [64];
    initial
        for (int i = 0; i < 64; i++) mem[i] = 18'(i) ^ 18'h2AAAA;
    // Outside a read the data is inverted so a mistimed sample shows up
    assign rd_data_o = rd_i ? mem[rd_addr_i[5:0]] : ~mem[rd_addr_i[5:0]];
    always @(posedge clk_sys_i)
    begin
        if (wr_i && wr_lane_i[0]) mem[wr_addr_i[5:0]][8:0] <= wr_data_i[8:0];
        if (wr_i && wr_lane_i[1]) mem[wr_addr_i[5:0]][17:9] <= wr_data_i[17:9];
    end
endmodule

//--- tb/sram_port_checker.sv
// Pin-level assertions for the pipelined SRAM port.
// Bound into sram_port; sees only its ports.
`timescale 1ns/1ps
module sram_port_checker (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic clk_gate_b_i,
    input wire logic [sram_port_pkg::ADDR_W-1:0] addr_i,
    input wire logic read_not_write_i,
    input wire logic advance_or_load_i,
    input wire logic chip_sel_b_i,
    input wire logic chip_sel_low_b_i,
    input wire logic chip_sel_high_i,
    input wire logic [sram_port_pkg::LANES-1:0] byte_write_low_i,
    input wire logic out_en_b_i,
    input wire logic snooze_request_i,
    input wire logic burst_order_i,
    input wire logic [sram_port_pkg::LANES-1:0] data_pin_oe_o,
    input wire logic [sram_port_pkg::ADDR_W-1:0] core_rd_addr_o,
    input wire logic core_rd_o,
    input wire logic [sram_port_pkg::ADDR_W-1:0] core_wr_addr_o,
    input wire logic core_wr_o,
    input wire logic [sram_port_pkg::LANES-1:0] core_wr_lane_o,
    input wire logic standby_o
);
    logic go;
    logic sel;
    logic [1:0] alo;
    logic [sram_port_pkg::ADDR_W-3:0] ahi;
    assign go = !clk_gate_b_i && !snooze_request_i;
    assign sel = !chip_sel_b_i && !chip_sel_low_b_i && chip_sel_high_i;
    assign alo = addr_i[1:0];
    assign ahi = addr_i[sram_port_pkg::ADDR_W-1:2];
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_ld_rd;
        go && !advance_or_load_i && sel && read_not_write_i;
    endsequence
    sequence s_ld_wr;
        go && !advance_or_load_i && sel && !read_not_write_i;
    endsequence
    // Gated edges do not count, so every pipeline step needs an ungated edge
    sequence s_go2;
        go ##1 go;
    endsequence
    AST_RD_ISSUE: assert property (s_ld_rd ##1 go |=> core_rd_o && core_rd_addr_o == $past(addr_i, 2))
        else $error("read not issued to array");
    AST_WR_COMMIT: assert property (s_ld_wr ##0 byte_write_low_i != 2'h3 ##1 s_go2 |=> core_wr_o &&
        core_wr_addr_o == $past(addr_i, 3) && core_wr_lane_o == ~$past(byte_write_low_i, 3))
        else $error("write commit wrong");
    AST_WR_ABORT: assert property (s_ld_wr ##0 byte_write_low_i == 2'h3 ##1 s_go2 |=> !core_wr_o)
        else $error("aborted write reached array");
    AST_GATE_HOLD: assert property (!go |=> $stable(core_rd_addr_o) && $stable(core_wr_addr_o) && !core_wr_o)
        else $error("state moved on gated edge");
    AST_DESEL_FLOAT: assert property (go && !advance_or_load_i && !sel ##1 s_go2 |=> data_pin_oe_o == 2'h0)
        else $error("pins driven after deselect");
    AST_RD_DRIVE: assert property (s_ld_rd ##1 go ##1 (go && !out_en_b_i) |=> data_pin_oe_o == 2'h3)
        else $error("read data not driven");
    AST_OE_OFF: assert property (out_en_b_i || snooze_request_i |=> data_pin_oe_o == 2'h0)
        else $error("pins driven while disabled");
    AST_SNOOZE: assert property (snooze_request_i |=> standby_o)
        else $error("standby not reported");
    AST_BURST_STEP: assert property (s_ld_rd ##1 (go && advance_or_load_i) ##1 go |=> core_rd_o &&
        core_rd_addr_o == {$past(ahi, 3), burst_order_i ? $past(alo, 3) ^ 2'h1 : $past(alo, 3) + 2'h1})
        else $error("burst step address wrong");
endmodule

bind sram_port sram_port_checker i_sram_port_checker (.clk_sys_i, .rst_i, .clk_gate_b_i, .addr_i,
    .read_not_write_i, .advance_or_load_i, .chip_sel_b_i, .chip_sel_low_b_i, .chip_sel_high_i,
    .byte_write_low_i, .out_en_b_i, .snooze_request_i, .burst_order_i, .data_pin_oe_o,
    .core_rd_addr_o, .core_rd_o, .core_wr_addr_o, .core_wr_o, .core_wr_lane_o, .standby_o);

//--- tb/tb_sram_port.sv
// Random controller traffic on the SRAM port, checked against a queue model.
// Assumes the cell array model on the core side and a 50 ns clock.
`timescale 1ns/1ps
module tb_sram_port;
    typedef struct {int op; int a; int bw;} ent_type;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, clk_gate_b_i = 1'b0, read_not_write_i = 1'b0;
    logic advance_or_load_i = 1'b1, chip_sel_b_i = 1'b1, chip_sel_low_b_i = 1'b0, chip_sel_high_i = 1'b1;
    logic out_en_b_i = 1'b0, snooze_request_i = 1'b0, burst_order_i = 1'b1, standby_o, core_rd_o, core_wr_o;
    logic test_clk_i = 1'b0, test_mode_i = 1'b1, test_data_i = 1'b0, test_data_o, test_data_oe_o;
    logic [1:0] byte_write_low_i = 2'h0, data_pin_oe_o, core_wr_lane_o;
    logic [18:0] addr_i = 19'h0, core_rd_addr_o, core_wr_addr_o;
    logic [17:0] data_pin_i = 18'h0, data_pin_o, core_rd_data_i, core_wr_data_o;
    logic [17:0] ref_mem [64];
    ent_type pipe [$];
    int seed, fails, num_checks, cycles, live, dir, base, step;
    always #25 clk_sys_i = ~clk_sys_i;
    sram_port i_sram_port (.clk_sys_i, .rst_i, .clk_gate_b_i, .addr_i, .read_not_write_i, .advance_or_load_i,
        .chip_sel_b_i, .chip_sel_low_b_i, .chip_sel_high_i, .byte_write_low_i, .out_en_b_i, .snooze_request_i,
        .burst_order_i, .data_pin_i, .data_pin_o, .data_pin_oe_o, .core_rd_addr_o, .core_rd_o, .core_rd_data_i,
        .core_wr_addr_o, .core_wr_o, .core_wr_lane_o, .core_wr_data_o, .standby_o, .test_clk_i, .test_mode_i,
        .test_data_i, .test_data_o, .test_data_oe_o);
    sram_cell_array i_sram_cell_array (.clk_sys_i, .rd_addr_i(core_rd_addr_o), .rd_i(core_rd_o),
        .rd_data_o(core_rd_data_i), .wr_addr_i(core_wr_addr_o), .wr_i(core_wr_o), .wr_lane_i(core_wr_lane_o),
        .wr_data_i(core_wr_data_o));
    task automatic chk_word(input logic [18:0] act, input logic [18:0] exp);
        num_checks++;
        if (act !== exp)
        begin
            fails++;
            $display("[ERR] %0t word %h expected %h", $time, act, exp);
        end
    endtask
    task automatic chk_flag(input logic [1:0] act, input logic [1:0] exp);
        num_checks++;
        if (act !== exp)
        begin
            fails++;
            $display("[ERR] %0t flags %h expected %h", $time, act, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Arbitrary identity value, the scan port's default
    localparam logic [31:0] SCAN_ID = 32'h0000_0001;
    // One test clock period: low half, sample the output, then the rising half
    task automatic scan_bit(input logic tms, output logic tdo);
        test_mode_i <= tms;
        test_clk_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        tdo = test_data_o;
        test_clk_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
    endtask
    // Reference model: every ungated edge retires the command taken two ungated edges before
    always @(posedge clk_sys_i)
    begin
        ent_type e;
        ent_type n;
        logic [17:0] d;
        logic rd_on;
        if (rst_i)
        begin
            live = 0;
            pipe = '{'{0, 0, 0}, '{0, 0, 0}};
        end
        else if (!clk_gate_b_i && !snooze_request_i)
        begin
            e = pipe.pop_front();
            d = data_pin_i;
            rd_on = e.op == 1 && !out_en_b_i;
            if (!advance_or_load_i)
            begin
                live = !chip_sel_b_i && !chip_sel_low_b_i && chip_sel_high_i;
                dir = read_not_write_i ? 1 : 2;
                base = addr_i;
                step = 0;
            end
            else
                step = (step + 1) % 4;
            n.op = live ? dir : 0;
            n.a = base - base % 4 + (burst_order_i ? (base % 4) ^ step : (base + step) % 4);
            n.bw = byte_write_low_i;
            pipe.push_back(n);
            if (e.op == 2 && !e.bw[0]) ref_mem[e.a % 64][8:0] = d[8:0];
            if (e.op == 2 && !e.bw[1]) ref_mem[e.a % 64][17:9] = d[17:9];
            #1;
            chk_flag(data_pin_oe_o, rd_on ? 2'h3 : 2'h0);
            if (rd_on) chk_word({1'b0, data_pin_o}, {1'b0, ref_mem[e.a % 64]});
            chk_flag({1'b0, core_wr_o}, {1'b0, e.op == 2 && e.bw[1:0] != 2'h3});
            if (core_wr_o) chk_word(core_wr_addr_o, 19'(e.a));
            if (core_wr_o) chk_word({1'b0, core_wr_data_o}, {1'b0, d});
            if (core_wr_o) chk_flag(core_wr_lane_o, ~e.bw[1:0]);
        end
    end
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            fails++;
            give_verdict();
        end
    end
    initial
    begin
        logic [31:0] r;
        logic bit_out;
        seed = 52599;
        for (int i = 0; i < 64; i++) ref_mem[i] = 18'(i) ^ 18'h2AAAA;
        for (int ph = 0; ph < 3; ph++)
        begin
            repeat (3) @(posedge clk_sys_i);
            rst_i <= 1'b0;
            burst_order_i <= ph != 1;
            repeat (400)
            begin
                @(posedge clk_sys_i);
                r = $random(seed);
                clk_gate_b_i <= ph > 0 && r[2:0] == 3'h0;
                advance_or_load_i <= r[4:3] != 2'h0;
                read_not_write_i <= r[5];
                chip_sel_b_i <= r[9:6] == 4'h0;
                chip_sel_low_b_i <= r[9:6] == 4'h1;
                chip_sel_high_i <= r[9:6] != 4'h2;
                byte_write_low_i <= r[11:10];
                out_en_b_i <= r[14:12] == 3'h0;
                snooze_request_i <= ph == 2 && r[17:15] == 3'h0;
                // Upper bits follow bits 5:2, so the six low bits name one cell; bursts keep the mapping
                addr_i <= {r[31:28], 9'h000, r[31:26]};
                test_clk_i <= r[23];
                test_mode_i <= r[24];
                test_data_i <= r[25];
                data_pin_i <= 18'($random(seed));
            end
            // Deselect cycles drain pending writes before the next reset
            @(posedge clk_sys_i);
            advance_or_load_i <= 1'b0;
            chip_sel_b_i <= 1'b1;
            clk_gate_b_i <= 1'b0;
            snooze_request_i <= 1'b0;
            // Scan port rests in its reset state across the next release
            test_clk_i <= 1'b0;
            test_mode_i <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            rst_i <= 1'b1;
            $display("test %0d done, mismatches %0d", ph, fails);
        end
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // First step from reset also loads the identity instruction
        scan_bit(1'b0, bit_out);
        scan_bit(1'b1, bit_out);
        scan_bit(1'b0, bit_out);
        scan_bit(1'b0, bit_out);
        for (int k = 0; k < 32; k++)
        begin
            scan_bit(k == 31, bit_out);
            chk_flag({1'b0, bit_out}, {1'b0, SCAN_ID[k]});
            chk_flag({1'b0, test_data_oe_o}, 2'h1);
        end
        $display("test 3 done, mismatches %0d", fails);
        give_verdict();
    end
endmodule
